// >>> include/timer_consts.svh
/*
 * Register offsets, field positions and reset values of the timer
 * status-output block. Assumes a 32-bit APB slave decoding addr[11:0].
 */
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 12'h000
`define OFS_RESTART 12'h004
`define OFS_COUNT 12'h008
`define OFS_ENABLE 12'h00C
`define OFS_THR_A 12'h010
`define OFS_THR_B 12'h014
`define OFS_IRQ_STAT 12'h018
`define OFS_IRQ_MASK 12'h01C

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTRL_ENABLE 0
`define CTRL_ACTIVE 1
`define CTRL_AUTO_DIS 2
`define CTRL_AUTO_IDLE 3
`define CTRL_IRQ_EN 4
`define CTRL_SEL_LO 5
`define CTRL_SEL_HI 7
`define CTRL_INV 8
`define CTRL_STOP 9

// ----------------------------------------------------------------
// Interrupt status fields and reset values
// ----------------------------------------------------------------
`define IRQ_ZERO 0
`define IRQ_STOPPED 1
`define IRQ_W 2
`define WORD_RESET 32'h0000_0000

`endif

// >>> include/timer_pkg.sv
/*
 * Types shared by the timer status-output block.
 * Assumes the constants header is available alongside.
 */
package timer_pkg;

    // ----------------------------------------------------------------
    // Status output select modes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SEL_ZERO_PULSE = 3'b000,
        SEL_UNUSED1 = 3'b001,
        SEL_TOGGLE = 3'b010,
        SEL_AT_OR_ABOVE_A = 3'b011,
        SEL_BETWEEN_B_A = 3'b100,
        SEL_UNUSED5 = 3'b101,
        SEL_ACTIVE_A = 3'b110,
        SEL_RESERVED = 3'b111
    } status_sel_t;

    // ----------------------------------------------------------------
    // Software control settings
    // ----------------------------------------------------------------
    typedef struct packed {
        logic status_output_invert;
        status_sel_t sel;
        logic zero_interrupt_enable;
        logic zero_auto_idle;
        logic auto_disable;
    } ctrl_t;

endpackage

// >>> rtl/status_select.sv
/*
 * Picks the raw (pre-inversion) timer status from the count, the two
 * thresholds and the zero events. Pure combinational; the caller
 * registers the result.
 */
`timescale 1ns/1ps
module status_select
    import timer_pkg::*;
#(
    parameter int CNT_W = 32
) (
    // Mode
    input wire status_sel_t sel,
    // Count and thresholds
    input wire logic [CNT_W-1:0] current_count,
    input wire logic [CNT_W-1:0] threshold_a_value,
    input wire logic [CNT_W-1:0] threshold_b_value,
    // Zero related
    input wire logic zero_event,
    input wire logic toggle_level,
    // Result
    output logic status_raw
);

    wire logic ge_a = current_count >= threshold_a_value;
    wire logic ge_b = current_count >= threshold_b_value;
    wire logic nonzero = |current_count;

    wire logic m_pulse = (sel == SEL_ZERO_PULSE) & zero_event;
    wire logic m_toggle = (sel == SEL_TOGGLE) & toggle_level;
    wire logic m_ge_a = (sel == SEL_AT_OR_ABOVE_A) & ge_a;
    wire logic m_win = (sel == SEL_BETWEEN_B_A) & ~ge_a & ge_b;
    wire logic m_act = (sel == SEL_ACTIVE_A) & nonzero & (~ge_a | (current_count == threshold_a_value));

    // unused and reserved codes stay low
    assign status_raw = m_pulse | m_toggle | m_ge_a | m_win | m_act;

endmodule

// >>> rtl/timer_status_output_control.sv
/*
 * Down-counting timer with status output selection, auto disable and
 * auto idle at zero, stop request, zero interrupt and an APB slave.
 * Assumes a single 20 MHz clock; count_gate comes from logic on the
 * same clock (cascade gating lives outside this block).
 */
// The APB register port and the register addresses were chosen for this implementation.
// What this block does
// - Active goes high the first clock after enable once the count changes.
// - Auto-disable clears enable and active when the count reaches zero.
// - Auto-idle alone clears only active at zero; implied by auto-disable.
// - Zero interrupt, when enabled, is high exactly one cycle per zero.
// - Status output feeds cascade inputs and a general-purpose pin.
// - Select 0: status is a one-cycle pulse at each zero.
// - Select 2: status toggles at each zero, dividing by two.
// - Select 3: status is one while count is at or above A.
// - Select 4: status is one while count is below A, at/above B.
// - Select 6: status is one while count is nonzero and at most A.
// - Control bit 8 inverts the selected status; resets low.
// - Writing control bit 9 stops the counter on its next count cycle.
// - Enabled counter reloads from restart value at zero.
// - Writing zero to the count while enabled acts as reaching zero.
`timescale 1ns/1ps
`include "timer_consts.svh"
module timer_status_output_control
    import timer_pkg::*;
#(
    parameter int CNT_W = 32
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Count gating from cascade logic
    input wire logic count_gate,
    // Status outputs
    output logic cascade_status,
    output logic pin_status,
    // Interrupts
    output logic zero_irq,
    output logic irq
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
        $error("CNT_W must lie between 2 and 32");
    end

    // ----------------------------------------------------------------
    // Reset synchroniser
    // ----------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    ctrl_t ctrl_q;
    logic enable_q;
    logic active_q;
    logic stop_q;
    logic toggle_q;
    logic zero_pulse_q;
    logic status_q;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_prev_q;
    logic [CNT_W-1:0] restart_q;
    logic [CNT_W-1:0] thr_a_q;
    logic [CNT_W-1:0] thr_b_q;
    logic [`IRQ_W-1:0] irq_stat_q;
    logic [`IRQ_W-1:0] irq_mask_q;
    logic [31:0] prdata_q;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire logic setup = psel & ~penable;
    wire logic access = psel & penable;
    wire logic wr = access & pwrite;
    wire logic rd_setup = setup & ~pwrite;
    wire logic hit_ctrl = paddr == `OFS_CTRL;
    wire logic hit_restart = paddr == `OFS_RESTART;
    wire logic hit_count = paddr == `OFS_COUNT;
    wire logic hit_enable = paddr == `OFS_ENABLE;
    wire logic hit_thr_a = paddr == `OFS_THR_A;
    wire logic hit_thr_b = paddr == `OFS_THR_B;
    wire logic hit_stat = paddr == `OFS_IRQ_STAT;
    wire logic hit_mask = paddr == `OFS_IRQ_MASK;
    wire logic mapped = hit_ctrl | hit_restart | hit_count | hit_enable
                      | hit_thr_a | hit_thr_b | hit_stat | hit_mask;
    wire logic wr_ctrl = wr & hit_ctrl;
    wire logic wr_count = wr & hit_count;
    wire logic wr_enable = wr & hit_enable;
    wire logic rd_stat_done = access & ~pwrite & hit_stat;
    wire logic [CNT_W-1:0] wdata = pwdata[CNT_W-1:0];

    // upper control bits read as zero
    wire logic [31:0] ctrl_rd = {22'h00_0000, stop_q, ctrl_q.status_output_invert,
                                 ctrl_q.sel, ctrl_q.zero_interrupt_enable,
                                 ctrl_q.zero_auto_idle, ctrl_q.auto_disable,
                                 active_q, enable_q};

    wire logic [31:0] rd_mux =
        hit_ctrl ? ctrl_rd :
        hit_restart ? 32'(restart_q) :
        hit_count ? 32'(count_q) :
        hit_enable ? 32'(enable_q) :
        hit_thr_a ? 32'(thr_a_q) :
        hit_thr_b ? 32'(thr_b_q) :
        hit_stat ? 32'(irq_stat_q) :
        hit_mask ? 32'(irq_mask_q) : `WORD_RESET;

    // Zero wait states: the answer stands in the access cycle
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = prdata_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= `WORD_RESET;
        end else if (rd_setup) begin
            prdata_q <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // Counting and zero events
    // ----------------------------------------------------------------
    wire logic count_cycle = enable_q & count_gate;
    // stop takes the place of a normal count step
    wire logic stop_hit = count_cycle & stop_q & ~wr_count;
    wire logic tick = count_cycle & ~stop_q & ~wr_count;
    wire logic [CNT_W-1:0] count_step = (count_q == '0) ? restart_q : count_q - 1'b1;
    // software zero write counts as reaching zero
    wire logic zero_evt = (enable_q & wr_count & (wdata == '0))
                        | (tick & (count_step == '0));
    wire logic [CNT_W-1:0] count_d = wr_count ? wdata : tick ? count_step : count_q;

    wire logic auto_off = zero_evt & ctrl_q.auto_disable;
    // idle at zero, implied by auto disable
    wire logic auto_idle = zero_evt & (ctrl_q.zero_auto_idle | ctrl_q.auto_disable);

    wire logic enable_set = (wr_ctrl & pwdata[`CTRL_ENABLE])
                          | (wr_enable & pwdata[`CTRL_ENABLE]);
    wire logic enable_wr = wr_ctrl | wr_enable;
    wire logic enable_clr = auto_off | stop_hit;
    // Software write wins over a hardware clear in the same cycle
    wire logic enable_d = enable_wr ? enable_set : (enable_q & ~enable_clr);

    // active after enable once the count has moved
    wire logic active_d = (enable_clr | auto_idle | ~enable_q) ? 1'b0 :
                          (active_q | (count_q != count_prev_q));

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
            count_prev_q <= '0;
            enable_q <= 1'b0;
            active_q <= 1'b0;
        end else begin
            count_q <= count_d;
            count_prev_q <= count_q;
            enable_q <= enable_d;
            active_q <= active_d;
        end
    end

    // stop request held until the next count cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_q <= 1'b0;
        end else if (wr_ctrl & pwdata[`CTRL_STOP]) begin
            stop_q <= 1'b1;
        end else if (stop_hit | ~enable_q) begin
            stop_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= '0;
            restart_q <= '0;
            thr_a_q <= '0;
            thr_b_q <= '0;
            irq_mask_q <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= ctrl_t'(pwdata[`CTRL_INV:`CTRL_AUTO_DIS]);
            end
            if (wr & hit_restart) begin
                restart_q <= wdata;
            end
            if (wr & hit_thr_a) begin
                thr_a_q <= wdata;
            end
            if (wr & hit_thr_b) begin
                thr_b_q <= wdata;
            end
            if (wr & hit_mask) begin
                irq_mask_q <= pwdata[`IRQ_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Status output
    // ----------------------------------------------------------------
    logic status_raw;

    status_select #(
        .CNT_W(CNT_W)
    ) u_sel (
        .sel(ctrl_q.sel),
        .current_count(count_q),
        .threshold_a_value(thr_a_q),
        .threshold_b_value(thr_b_q),
        .zero_event(zero_evt),
        .toggle_level(toggle_q ^ zero_evt),
        .status_raw(status_raw)
    );

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            toggle_q <= 1'b0;
            zero_pulse_q <= 1'b0;
            status_q <= 1'b0;
        end else begin
            toggle_q <= toggle_q ^ zero_evt;
            zero_pulse_q <= zero_evt & ctrl_q.zero_interrupt_enable;
            status_q <= status_raw ^ ctrl_q.status_output_invert;
        end
    end

    // same status to cascade and pin
    assign cascade_status = status_q;
    assign pin_status = status_q;
    assign zero_irq = zero_pulse_q;

    // ----------------------------------------------------------------
    // Sticky interrupt status
    // ----------------------------------------------------------------
    wire logic [`IRQ_W-1:0] irq_set = {stop_hit, zero_evt};
    // Only bits that the read returned are cleared, so a late event survives
    wire logic [`IRQ_W-1:0] irq_clr = rd_stat_done ? prdata_q[`IRQ_W-1:0] : '0;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // pulse width
    zero_irq_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        zero_irq |=> !zero_irq || $past(zero_evt))
        else $error("zero interrupt longer than a zero event");

    zero_irq_cause_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        zero_evt && ctrl_q.zero_interrupt_enable |=> zero_irq)
        else $error("zero event raised no interrupt");

    auto_disable_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        auto_off && !enable_wr |=> !enable_q && !active_q)
        else $error("auto disable left the counter enabled");

    auto_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        zero_evt && ctrl_q.zero_auto_idle && !ctrl_q.auto_disable && !enable_wr
        |=> !active_q && enable_q)
        else $error("auto idle did not clear only active");

    stop_request_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        stop_hit && !enable_wr |=> !enable_q && !active_q && $stable(count_q))
        else $error("stop request did not halt the counter");

    reload_value_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tick && count_q == '0 |=> count_q == $past(restart_q))
        else $error("counter did not reload at zero");

    pulse_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ctrl_q.sel == SEL_ZERO_PULSE && !ctrl_q.status_output_invert && $stable(ctrl_q)
        |-> ##1 (status_q == $past(zero_evt)))
        else $error("pulse mode status mismatch");

    compare_a_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ctrl_q.sel == SEL_AT_OR_ABOVE_A && $stable(ctrl_q)
        |-> ##1 (status_q == (($past(count_q) >= $past(thr_a_q))
                 ^ $past(ctrl_q.status_output_invert))))
        else $error("threshold A compare mismatch");

    zero_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        enable_q && wr_count && pwdata == '0 |-> zero_evt ##1 irq_stat_q[`IRQ_ZERO])
        else $error("zero write did not act as reaching zero");

    activation_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        enable_q && !active_q && tick && !zero_evt && !stop_q
        ##1 enable_q && !enable_clr && !auto_idle
        |=> active_q)
        else $error("counter did not become active");

endmodule

// >>> tb/tb_timer_status_output_control.sv
/*
 * Self-checking bench for the timer status-output block.
 * Assumes the design's package and constants header; drives APB and count_gate itself.
 */
`timescale 1ns/1ps
`include "timer_consts.svh"
module tb_timer_status_output_control
    import timer_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals and constants
    // ----------------------------------------------------------------
    localparam logic [31:0] C_EN = 32'h0000_0001;
    localparam logic [31:0] C_AD = 32'h0000_0004;
    localparam logic [31:0] C_AI = 32'h0000_0008;
    localparam logic [31:0] C_IE = 32'h0000_0010;
    localparam logic [31:0] C_INV = 32'h0000_0100;
    localparam logic [31:0] C_STOP = 32'h0000_0200;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic count_gate = 1'b1;
    logic cascade_status;
    logic pin_status;
    logic zero_irq;
    logic irq;
    int n_fail = 0;
    int checks_done = 0;
    logic smp [64];
    logic [31:0] q;
    logic err;

    always #25 ref_clk = ~ref_clk;

    timer_status_output_control #(.CNT_W(32)) i_dut (
        .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .count_gate(count_gate), .cascade_status(cascade_status),
        .pin_status(pin_status), .zero_irq(zero_irq), .irq(irq)
    );

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("Checks done %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Request held from setup until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) begin
            n_fail++;
            tally_and_finish();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    function automatic logic exp_stat(input logic [2:0] sel, input logic [31:0] c,
                                      input logic [31:0] a, input logic [31:0] b);
        case (sel)
            3'd3: return c >= a;
            3'd4: return (c < a) && (c >= b);
            3'd6: return (c != 0) && (c <= a);
            default: return 1'b0;
        endcase
    endfunction

    // Rises of the sampled signal: period between two and width of one
    task automatic periodic(input logic which, input int per, input int wid, input string nm);
        int r[$];
        int w;
        for (int i = 0; i < 40; i++) begin
            @(posedge ref_clk);
            smp[i] = which ? zero_irq : cascade_status;
        end
        for (int i = 1; i < 40; i++) begin
            if (smp[i] === 1'b1 && smp[i-1] === 1'b0) r.push_back(i);
        end
        chk({nm, " rises"}, 32'(r.size() >= 3), 32'h0000_0001);
        if (r.size() >= 3) begin
            w = 0;
            for (int i = r[1]; i < r[2]; i++) w += (smp[i] === 1'b1);
            chk({nm, " period"}, 32'(r[2] - r[1]), 32'(per));
            chk({nm, " width"}, 32'(w), 32'(wid));
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        rd(`OFS_CTRL);
        chk("ctrl reset", q, `WORD_RESET);
        wr(`OFS_CTRL, 32'hFFFF_FC00);
        rd(`OFS_CTRL);
        chk("ctrl upper bits", q, 32'h0000_0000);
        rd(12'h020);
        chk("unmapped err", 32'(err), 32'h0000_0001);
        chk("unmapped data", q, 32'h0000_0000);
    endtask

    // Counter held disabled so the compare modes see a fixed count
    task automatic t_compare();
        logic [31:0] cv [6] = '{32'd12, 32'd10, 32'd9, 32'd4, 32'd3, 32'd0};
        logic [2:0] sv [6] = '{3'd3, 3'd4, 3'd6, 3'd7, 3'd1, 3'd5};
        logic e;
        wr(`OFS_THR_A, 32'd10);
        wr(`OFS_THR_B, 32'd4);
        for (int m = 0; m < 6; m++) begin
            for (int v = 0; v < 2; v++) begin
                wr(`OFS_CTRL, (32'(sv[m]) << 5) | (v ? C_INV : 32'h0000_0000));
                for (int k = 0; k < 6; k++) begin
                    wr(`OFS_COUNT, cv[k]);
                    cyc(3);
                    e = exp_stat(sv[m], cv[k], 32'd10, 32'd4) ^ v[0];
                    chk("compare cascade", 32'(cascade_status), 32'(e));
                    chk("compare pin", 32'(pin_status), 32'(e));
                end
            end
        end
    endtask

    task automatic t_periodic();
        wr(`OFS_RESTART, 32'd2);
        wr(`OFS_COUNT, 32'd2);
        wr(`OFS_CTRL, C_EN | C_IE);
        periodic(1'b0, 3, 1, "zero pulse");
        periodic(1'b1, 3, 1, "zero irq");
        wr(`OFS_CTRL, C_EN | (32'd2 << 5));
        periodic(1'b0, 6, 3, "toggle");
        wr(`OFS_CTRL, 32'h0000_0000);
    endtask

    // One run to zero with auto-disable, interrupt masked or not
    task automatic t_one_shot(input logic msk);
        int nz;
        int ns;
        rd(`OFS_IRQ_STAT);
        wr(`OFS_IRQ_MASK, 32'(msk));
        wr(`OFS_RESTART, 32'd7);
        wr(`OFS_COUNT, 32'd3);
        wr(`OFS_CTRL, C_EN | C_AD | C_IE);
        nz = 0;
        ns = 0;
        for (int i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            nz += (zero_irq === 1'b1);
            ns += (cascade_status === 1'b1);
        end
        chk("one shot irq cycles", 32'(nz), 32'd1);
        chk("one shot pulses", 32'(ns), 32'd1);
        rd(`OFS_CTRL);
        chk("auto disable", q & 32'h0000_0003, 32'h0000_0000);
        chk("irq level", 32'(irq), 32'(msk));
        rd(`OFS_IRQ_STAT);
        chk("irq stat zero", q & 32'h0000_0001, 32'h0000_0001);
        cyc(1);
        chk("irq cleared", 32'(irq), 32'h0000_0000);
        rd(`OFS_IRQ_STAT);
        chk("irq stat cleared", q & 32'h0000_0001, 32'h0000_0000);
    endtask

    task automatic t_active_stop();
        wr(`OFS_RESTART, 32'd50);
        wr(`OFS_COUNT, 32'd100);
        wr(`OFS_CTRL, C_EN);
        cyc(4);
        rd(`OFS_CTRL);
        chk("active set", q & 32'h0000_0003, 32'h0000_0003);
        wr(`OFS_CTRL, C_EN | C_STOP);
        cyc(4);
        rd(`OFS_CTRL);
        chk("stop clears", q & 32'h0000_0003, 32'h0000_0000);
        rd(`OFS_COUNT);
        chk("stopped nonzero", 32'(q != 0), 32'h0000_0001);
        wr(`OFS_COUNT, 32'd3);
        wr(`OFS_CTRL, C_EN | C_AI);
        cyc(10);
        rd(`OFS_CTRL);
        chk("auto idle keeps enable", q & 32'h0000_0001, 32'h0000_0001);
        rd(`OFS_ENABLE);
        chk("enable alias read", q, 32'h0000_0001);
        wr(`OFS_CTRL, 32'h0000_0000);
    endtask

    // Gate held low so only the software write of zero can cause the event
    task automatic t_write_zero();
        int nz;
        count_gate <= 1'b0;
        wr(`OFS_COUNT, 32'd1000);
        // Enable through the alias register so its write path is exercised
        wr(`OFS_CTRL, C_IE);
        wr(`OFS_ENABLE, C_EN);
        cyc(5);
        nz = 0;
        fork
            wr(`OFS_COUNT, 32'd0);
            for (int i = 0; i < 12; i++) begin
                @(posedge ref_clk);
                nz += (zero_irq === 1'b1);
            end
        join
        chk("write zero event", 32'(nz), 32'd1);
        wr(`OFS_CTRL, 32'h0000_0000);
        count_gate <= 1'b1;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        cyc(8);
        nrst <= 1'b1;
        cyc(4);
        t_regs();
        t_compare();
        t_periodic();
        t_one_shot(1'b1);
        t_one_shot(1'b0);
        t_active_stop();
        t_write_zero();
        tally_and_finish();
    end
endmodule
